/* File: hw/ems_pkg.sv */
// Constants, field layout and state encoding of the link fault monitor
//------------------------------------------------------------------------
// Overview of operation
// - Three-bit fault register, all bits reset zero
// - Write transfers echo pattern plus fault bits
// - First captured fault freezes register, later ignored
// - Interrupt raised on capture when enable set
// - Error state accepts only the recovery command
// - Recovery sends one word, exits, drops interrupt
// - Generic target returns code and clears register
// - Select low without system clock flags clock
// - Data word count mismatch flags burst fault
// - Paced mode idle timeout aborts, flags burst
// - Held select mismatch flags; extra write commits
// - Wrong bit count in word flags bit fault
// - Back-to-back bit fault reported at sequence end
// - Paced gap beyond timeout enters error state
//------------------------------------------------------------------------
package ems_pkg;

    // Word and field geometry
    localparam int WORD_W = 16;
    localparam int FLAG_W = 3;
    localparam int ADDR_W = 10;
    localparam int CNT_W = 5;
    localparam int BITCNT_W = 4;

    // Command word fields
    localparam int CMD_RW_POS = 15;
    localparam int CMD_ADDR_LSB = 5;
    localparam int CMD_CNT_LSB = 0;

    // Fault bit positions
    localparam int FLT_CLK_POS = 2;
    localparam int FLT_FRAME_POS = 1;
    localparam int FLT_WORD_POS = 0;

    // Register addresses
    localparam logic [ADDR_W-1:0] FAULT_REG_ADDR = 10'h1D3;
    localparam logic [ADDR_W-1:0] LINK_CFG_ADDR = 10'h1C8;

    // Special values
    localparam logic [WORD_W-1:0] RECOVER_CMD = 16'hBA61;
    localparam logic [WORD_W-1:0] SEL_GENERIC = 16'h0004;
    localparam logic [12:0] DIAG_PATTERN = 13'h1555;
    localparam logic [WORD_W-1:0] ARB_WORD = 16'h0000;
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

    // Reset value and last bit count
    localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 4'hF;

    // Protocol states, Gray along idle, data, error, recovery
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DATA = 2'h1,
        ST_ERR = 2'h3,
        ST_RECOV = 2'h2
    } ems_state_t;

endpackage : ems_pkg

/* File: hw/ems_sync.sv */
// Two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/100ps
module ems_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] q
);
    // First stage, read only by the second
    logic [W-1:0] meta_q;
    // Second stage, safe to use
    logic [W-1:0] sync_q;

    // Both stages load a reset value chosen per bit
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= rst_val;
            sync_q <= rst_val;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule : ems_sync

/* File: hw/ems_watchdog.sv */
// Inactivity counter for paced-burst transfers
`timescale 1ns/100ps
module ems_watchdog #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic kick,
    input wire logic [W-1:0] limit,
    output logic expired
);
    // Idle cycles seen since last activity
    logic [W-1:0] cnt_q;

    // Count while armed, restart on any link activity
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!run || kick) begin
            cnt_q <= '0;
        end else if (cnt_q != limit) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Limit reached while still idle means the gap is too long
    assign expired = run && !kick && (cnt_q == limit);

endmodule : ems_watchdog

/* File: hw/ems_spi_error_monitor.sv */
// Link slave protocol with fault capture, echo and recovery
`timescale 1ns/100ps
module ems_spi_error_monitor #(
    parameter int WD_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic sys_clk_ok,
    input wire logic paced_mode,
    input wire logic fault_irq_en,
    input wire logic [WD_W-1:0] wd_limit,
    input wire logic [ems_pkg::WORD_W-1:0] target_sel,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    output logic fault_irq,
    output logic err_state,
    output logic [ems_pkg::FLAG_W-1:0] fault_flags,
    output logic wr_strobe,
    output logic [ems_pkg::ADDR_W-1:0] wr_addr,
    output logic [ems_pkg::WORD_W-1:0] wr_data
);
    import ems_pkg::*;
    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    // True when an address selects the fault register
    function automatic logic is_fault_addr(input logic [ADDR_W-1:0] a);
        is_fault_addr = (a == FAULT_REG_ADDR);
    endfunction : is_fault_addr

    // Read data for an address; other targets live elsewhere
    function automatic logic [WORD_W-1:0] rd_value(
        input logic [ADDR_W-1:0] a,
        input logic [FLAG_W-1:0] f
    );
        rd_value = is_fault_addr(a) ? {13'h0000, f} : ZERO_WORD;
    endfunction : rd_value

    //--------------------------------------------------------------------
    // Pin synchronisation and edge detection
    //--------------------------------------------------------------------
    logic sck_s; // Synced serial clock
    logic csn_s; // Synced select, active low
    logic mosi_s; // Synced data in
    logic clkok_s; // Synced system clock status
    logic sck_d1_q; // Previous serial clock level
    logic csn_d1_q; // Previous select level
    ems_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({spi_sck, spi_cs_n, spi_mosi, sys_clk_ok}),
        .rst_val(4'h6),
        .q({sck_s, csn_s, mosi_s, clkok_s})
    );

    // Delayed copies for edge finding
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_d1_q <= 1'b0;
            csn_d1_q <= 1'b1;
        end else begin
            sck_d1_q <= sck_s;
            csn_d1_q <= csn_s;
        end
    end

    logic sck_rise; // Sample edge inside a selection
    logic sck_fall; // Shift edge inside a selection
    logic cs_fall; // Selection starts
    logic cs_rise; // Selection ends
    assign sck_rise = sck_s && !sck_d1_q && !csn_s;
    assign sck_fall = !sck_s && sck_d1_q && !csn_s;
    assign cs_fall = !csn_s && csn_d1_q;
    assign cs_rise = csn_s && !csn_d1_q;

    //--------------------------------------------------------------------
    // Receive shifter
    //--------------------------------------------------------------------
    logic [WORD_W-1:0] rx_q; // Incoming bits, MSB first
    logic [BITCNT_W-1:0] bit_cnt_q; // Bits of current word
    logic word_done; // Sixteenth bit sampled
    logic [WORD_W-1:0] rx_word; // Completed word
    assign word_done = sck_rise && (bit_cnt_q == LAST_BIT);
    assign rx_word = {rx_q[WORD_W-2:0], mosi_s};

    // Bit counter runs across words while select stays low
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_q <= ZERO_WORD;
            bit_cnt_q <= '0;
        end else if (cs_rise) begin
            bit_cnt_q <= '0;
        end else if (sck_rise) begin
            rx_q <= rx_word;
            bit_cnt_q <= bit_cnt_q + 1'b1;
        end
    end

    //--------------------------------------------------------------------
    // Protocol state
    //--------------------------------------------------------------------
    ems_state_t state_q, state_d; // Protocol state
    logic rw_q, rw_d; // Burst is a read
    logic [ADDR_W-1:0] addr_q, addr_d; // Current target address
    logic [CNT_W-1:0] cnt_q, cnt_d; // Announced word count
    logic [CNT_W:0] words_q, words_d; // Data words seen
    logic [FLAG_W-1:0] flags_q; // Captured fault code
    logic irq_q; // Pending interrupt
    logic sel_gen_q; // Generic target chosen at fault
    logic tx_load; // Load a new outgoing word
    logic [WORD_W-1:0] tx_val; // Word to load
    logic wr_fire; // Commit a data word
    logic flag_clr; // Fault register read out
    logic irq_clr; // Recovery drops interrupt
    logic wd_exp; // Paced gap too long
    logic [FLAG_W-1:0] f_vec; // Faults detected now
    logic fault_cap; // Faults accepted now
    logic [WORD_W-1:0] diag_word; // Echo word for writes
    // Fixed pattern above the live fault bits
    assign diag_word = {DIAG_PATTERN, flags_q};
    ems_watchdog #(.W(WD_W)) u_wd (
        .clk(clk),
        .rst(rst),
        .run(paced_mode && (state_q == ST_DATA)),
        .kick(sck_rise || sck_fall || cs_fall || cs_rise),
        .limit(wd_limit),
        .expired(wd_exp)
    );

    // Fault detection per kind
    always_comb begin
        f_vec = '0;
        // Selection requested with no system clock
        f_vec[FLT_CLK_POS] = cs_fall && !clkok_s;
        // Partial word at end of selection only
        f_vec[FLT_WORD_POS] = cs_rise && (bit_cnt_q != '0);
        // Burst length faults per mode
        if (state_q == ST_DATA) begin
            if (paced_mode) begin
                f_vec[FLT_FRAME_POS] = wd_exp;
            end else if (cnt_q != '0) begin
                // Too short at deselect, or one word too many
                f_vec[FLT_FRAME_POS] =
                    (cs_rise && (words_q < {1'b0, cnt_q})) ||
                    (word_done && (words_q == {1'b0, cnt_q}));
            end
        end
    end

    // Only the first fault is kept; set wins over a read clear
    assign fault_cap = (f_vec != '0) &&
                       ((flags_q == FLAGS_RST) || flag_clr);

    // Next protocol state and outgoing word
    always_comb begin
        state_d = state_q;
        rw_d = rw_q;
        addr_d = addr_q;
        cnt_d = cnt_q;
        words_d = words_q;
        tx_load = cs_fall || word_done;
        tx_val = diag_word;
        wr_fire = 1'b0;
        flag_clr = 1'b0;
        irq_clr = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // Command word decode
                if (word_done) begin
                    rw_d = rx_word[CMD_RW_POS];
                    addr_d = rx_word[CMD_RW_POS-1:CMD_ADDR_LSB];
                    cnt_d = rx_word[CMD_ADDR_LSB-1:CMD_CNT_LSB];
                    words_d = '0;
                    // Paced long frames with zero count are ignored
                    if (!(paced_mode && (cnt_d == '0))) begin
                        state_d = ST_DATA;
                        if (rw_d) begin
                            tx_val = rd_value(addr_d, flags_q);
                            flag_clr = is_fault_addr(addr_d);
                        end
                    end
                end
            end
            ST_DATA: begin
                if (word_done) begin
                    words_d = words_q + 1'b1;
                    addr_d = addr_q + 1'b1;
                    // Extra held-select word is still committed
                    wr_fire = !rw_q;
                    if (rw_q) begin
                        tx_val = rd_value(addr_d, flags_q);
                        flag_clr = is_fault_addr(addr_d);
                    end
                    // Paced bursts end on the announced count
                    if (paced_mode && (words_d == {1'b0, cnt_q})) begin
                        state_d = ST_IDLE;
                    end
                end else if (cs_rise && !paced_mode) begin
                    // Held-select bursts end with the selection
                    state_d = ST_IDLE;
                end
            end
            ST_ERR: begin
                // Everything but the recovery command is dropped
                if (word_done && (rx_word == RECOVER_CMD)) begin
                    state_d = ST_RECOV;
                    irq_clr = 1'b1;
                    // Code only for the generic target
                    tx_val = sel_gen_q ? {13'h0000, flags_q}
                                       : ARB_WORD;
                    flag_clr = sel_gen_q;
                end
            end
            ST_RECOV: begin
                // One word out, then normal operation
                if (word_done || cs_rise) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        // A captured fault overrides the next state
        if (fault_cap) begin
            state_d = ST_ERR;
        end
    end

    // Protocol registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            rw_q <= 1'b0;
            addr_q <= '0;
            cnt_q <= '0;
            words_q <= '0;
        end else begin
            state_q <= state_d;
            rw_q <= rw_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            words_q <= words_d;
        end
    end

    //--------------------------------------------------------------------
    // Fault register, interrupt and target memory
    //--------------------------------------------------------------------
    // Fault code latch, frozen once non-zero
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= FLAGS_RST;
        end else if (fault_cap) begin
            flags_q <= f_vec;
        end else if (flag_clr) begin
            flags_q <= FLAGS_RST;
        end
    end

    // Target selection remembered at capture
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_gen_q <= 1'b0;
        end else if (fault_cap) begin
            sel_gen_q <= (target_sel == SEL_GENERIC);
        end
    end

    // Interrupt request, capture wins over recovery clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (fault_cap && fault_irq_en) begin
            irq_q <= 1'b1;
        end else if (irq_clr) begin
            irq_q <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Outgoing shifter and registered outputs
    //--------------------------------------------------------------------
    logic [WORD_W-1:0] tx_q, tx_d; // Outgoing bits
    logic miso_q; // Data out pin
    logic oe_n_q; // Data out enable, low drives
    logic err_q; // Error state flag
    logic wr_q; // Commit strobe
    logic [ADDR_W-1:0] wr_addr_q; // Commit address
    logic [WORD_W-1:0] wr_data_q; // Commit data
    // Shift on falling edges, not right after a reload
    always_comb begin
        tx_d = tx_q;
        if (tx_load) begin
            tx_d = tx_val;
        end else if (sck_fall && (bit_cnt_q != '0)) begin
            tx_d = {tx_q[WORD_W-2:0], 1'b0};
        end
    end

    // Data out and its enable
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q <= ZERO_WORD;
            miso_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            tx_q <= tx_d;
            miso_q <= tx_d[WORD_W-1];
            oe_n_q <= csn_s;
        end
    end

    // Status and commit outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= 1'b0;
            wr_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= ZERO_WORD;
        end else begin
            err_q <= (state_d == ST_ERR);
            wr_q <= wr_fire;
            if (wr_fire) begin
                wr_addr_q <= addr_q;
                wr_data_q <= rx_word;
            end
        end
    end

    assign spi_miso = miso_q;
    assign spi_miso_oe_n = oe_n_q;
    assign fault_irq = irq_q;
    assign err_state = err_q;
    assign fault_flags = flags_q;
    assign wr_strobe = wr_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
endmodule : ems_spi_error_monitor

/* File: test/ems_checker.sv */
// Port assertions for the link fault monitor
`timescale 1ns/100ps
module ems_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic sys_clk_ok,
    input wire logic fault_irq_en,
    input wire logic spi_miso_oe_n,
    input wire logic fault_irq,
    input wire logic err_state,
    input wire logic [ems_pkg::FLAG_W-1:0] fault_flags,
    input wire logic wr_strobe
);
    // ---------
    // Assertions
    // ---------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Held code only leaves by being cleared
    a_flag_freeze: assert property (
        fault_flags != 3'h0 |=> fault_flags == 3'h0 || $stable(fault_flags))
        else $error("held fault code changed");
    // Error state entered only with a fresh capture
    a_err_entry: assert property (
        $rose(err_state) |-> $past(fault_flags) == 3'h0 && fault_flags != 3'h0)
        else $error("error state without capture");
    // Enabled interrupt rises with the capture
    a_irq_on_capture: assert property (
        $rose(fault_flags != 3'h0) && $past(fault_irq_en) |-> fault_irq)
        else $error("interrupt missing at capture");
    // Interrupt never rises without entering error
    a_irq_cause: assert property (
        $rose(fault_irq) |-> $rose(err_state))
        else $error("interrupt without fault");
    // Leaving error leaves no interrupt pending
    a_irq_drop: assert property (
        $fell(err_state) |-> !fault_irq)
        else $error("interrupt left after recovery");
    // Echo driver follows chip select
    a_oe_drive: assert property (
        $fell(spi_cs_n) |-> ##[2:5] !spi_miso_oe_n)
        else $error("output not driven in frame");
    a_oe_release: assert property (
        $rose(spi_cs_n) |-> ##[2:5] spi_miso_oe_n)
        else $error("output not released after frame");
    // Select without system clock flags the clock fault
    a_clk_missing: assert property (
        $fell(spi_cs_n) && !sys_clk_ok && fault_flags == 3'h0
        |-> ##[2:8] fault_flags[2])
        else $error("missing clock not flagged");
    // Commit is a single pulse
    a_strobe_pulse: assert property (
        wr_strobe |=> !wr_strobe)
        else $error("commit pulse too long");

    // Main scenarios reached
    c_capture: cover property ($rose(err_state));
    c_recover: cover property ($fell(err_state));
    c_commit: cover property (wr_strobe);
endmodule : ems_checker

bind ems_spi_error_monitor ems_checker u_chk (
    .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .sys_clk_ok(sys_clk_ok),
    .fault_irq_en(fault_irq_en), .spi_miso_oe_n(spi_miso_oe_n),
    .fault_irq(fault_irq), .err_state(err_state),
    .fault_flags(fault_flags), .wr_strobe(wr_strobe));

/* File: test/ems_host_model.sv */
// Link master model that drives frames into the fault monitor
`timescale 1ns/100ps
module ems_host_model (
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    localparam realtime HALF = 62.5; // Half of the 125 ns link period

    // Idle: clock low and still, device deselected
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    // Select or deselect; a released data line never keeps stale data
    task automatic cs(input logic lvl);
        if (!lvl) begin
            cs_n = 1'b0;
            #HALF;
        end else begin
            #HALF;
            cs_n = 1'b1;
            mosi = ~mosi;
            #(4 * HALF);
        end
    endtask : cs

    // Shift n bits MSB first, sampling the echo on each rising edge
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        for (int i = 0; i < n; i++) begin
            mosi = w[15 - i];
            #HALF;
            sck = 1'b1;
            r = {r[14:0], miso};
            #HALF;
            sck = 1'b0;
        end
    endtask : xfer
endmodule : ems_host_model

/* File: test/tb_top.sv */
// Self-checking bench for the link fault monitor
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    import ems_pkg::*;
    // ---------
    // Table, signals and instances
    // ---------
    typedef struct {
        logic ok; // System clock status
        logic [4:0] cnt; // Announced count
        int nw; // Data words sent
        int lastb; // Bits in last word
        logic [2:0] flg; // Expected fault code
        int nc; // Expected commits
        logic en; // Interrupt enable
    } ems_row_t;
    ems_row_t rows [5] = '{
        '{1'b1, 5'h1, 1, 16, 3'h0, 1, 1'b1},
        '{1'b0, 5'h1, 1, 16, 3'h4, 0, 1'b1},
        '{1'b1, 5'h0, 1, 12, 3'h1, 0, 1'b1},
        '{1'b1, 5'h2, 1, 16, 3'h2, 1, 1'b0},
        '{1'b1, 5'h1, 2, 16, 3'h2, 2, 1'b1}};
    logic clk, rst, spi_sck, spi_cs_n, spi_mosi, sys_clk_ok;
    logic paced_mode, fault_irq_en, spi_miso, spi_miso_oe_n;
    logic fault_irq, err_state, wr_strobe;
    logic [15:0] wd_limit, target_sel, wr_data, last_data, e0, e1;
    logic [FLAG_W-1:0] fault_flags;
    logic [ADDR_W-1:0] wr_addr, last_addr;
    int error_cnt = 0;
    int samples_checked = 0;
    int commits = 0;
    int n0;

    ems_spi_error_monitor #(.WD_W(16)) u_dut (
        .clk(clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .sys_clk_ok(sys_clk_ok),
        .paced_mode(paced_mode), .fault_irq_en(fault_irq_en),
        .wd_limit(wd_limit), .target_sel(target_sel),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
        .fault_irq(fault_irq), .err_state(err_state),
        .fault_flags(fault_flags), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data));
    ems_host_model u_host (.sck(spi_sck), .cs_n(spi_cs_n),
        .mosi(spi_mosi), .miso(spi_miso));

    // 200 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count committed words and keep the last one
    always @(posedge clk) begin
        if (wr_strobe === 1'b1) begin
            commits++;
            last_data = wr_data;
            last_addr = wr_addr;
        end
    end

    // ---------
    // Tasks
    // ---------
    // Land just after an edge so input changes never race it
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // Held-select write: command, data words, last one maybe short
    task automatic frame(input logic [15:0] cmd, input int nw,
                         input int lastb);
        u_host.cs(1'b0);
        u_host.xfer(cmd, 16, e0);
        for (int i = 0; i < nw; i++) begin
            u_host.xfer(16'h5A3C, (i == nw - 1) ? lastb : 16, e1);
        end
        u_host.cs(1'b1);
    endtask : frame

    // Recovery command, then one word back
    task automatic recover(input logic [15:0] exp);
        logic [15:0] r;
        u_host.cs(1'b0);
        u_host.xfer(RECOVER_CMD, 16, r);
        u_host.xfer(16'h0000, 16, r);
        u_host.cs(1'b1);
        `CHK("recovery word", exp, r)
        `CHK("err exit", 1'b0, err_state)
        `CHK("irq drop", 1'b0, fault_irq)
    endtask : recover

    // Verdict and end of run
    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    // Hang guard, about three times the expected run
    initial begin
        #250000;
        error_cnt++;
        finish_test();
    end

    // ---------
    // Main sequence
    // ---------
    initial begin
        rst = 1'b1;
        sys_clk_ok = 1'b1;
        paced_mode = 1'b0;
        fault_irq_en = 1'b1;
        wd_limit = 16'h0028;
        target_sel = SEL_GENERIC;
        wait_clk(5);
        rst = 1'b0;
        wait_clk(4);
        `CHK("flags rst", 3'h0, fault_flags)
        `CHK("oe rst", 1'b1, spi_miso_oe_n)
        `CHK("irq rst", 1'b0, fault_irq)
        `CHK("err rst", 1'b0, err_state)
        // Table rows: one frame each, recover after any fault
        foreach (rows[i]) begin
            wait_clk(1);
            sys_clk_ok = rows[i].ok;
            fault_irq_en = rows[i].en;
            wait_clk(4);
            n0 = commits;
            frame({1'b0, 10'h055, rows[i].cnt}, rows[i].nw, rows[i].lastb);
            if (rows[i].ok) `CHK("echo", 16'hAAA8, e0)
            `CHK("flags", rows[i].flg, fault_flags)
            `CHK("err", rows[i].flg != 3'h0, err_state)
            `CHK("irq", rows[i].en && rows[i].flg != 3'h0, fault_irq)
            `CHK("commits", rows[i].nc, commits - n0)
            if (rows[i].nc > 0) begin
                `CHK("data", 16'h5A3C, last_data)
                `CHK("addr", 10'h055 + rows[i].nc - 1, last_addr)
            end
            if (rows[i].flg != 3'h0) begin
                wait_clk(1);
                sys_clk_ok = 1'b1;
                wait_clk(4);
                recover({13'h0000, rows[i].flg});
            end
        end
        // First fault kept, no interrupt, other target keeps code
        fault_irq_en = 1'b0;
        target_sel = 16'h0001;
        frame({1'b0, 10'h055, 5'h0}, 1, 12);
        `CHK("irq off", 1'b0, fault_irq)
        wait_clk(1);
        sys_clk_ok = 1'b0;
        wait_clk(4);
        frame({1'b0, 10'h055, 5'h1}, 1, 16);
        `CHK("frozen", 3'h1, fault_flags)
        wait_clk(1);
        sys_clk_ok = 1'b1;
        wait_clk(4);
        recover(16'h0000);
        `CHK("kept", 3'h1, fault_flags)
        frame({1'b1, FAULT_REG_ADDR, 5'h1}, 1, 16);
        `CHK("read code", 16'h0001, e1)
        `CHK("read clear", 3'h0, fault_flags)
        // Short word inside a held sequence shows only at its end
        fault_irq_en = 1'b1;
        target_sel = SEL_GENERIC;
        u_host.cs(1'b0);
        u_host.xfer({1'b0, 10'h055, 5'h0}, 16, e0);
        u_host.xfer(16'h5A3C, 16, e1);
        u_host.xfer(16'h5A3C, 10, e1);
        u_host.xfer(16'h5A3C, 16, e1);
        `CHK("late report", 3'h0, fault_flags)
        u_host.cs(1'b1);
        `CHK("seq end", 3'h1, fault_flags)
        recover(16'h0001);
        // Paced burst: short gaps pass, a long idle aborts
        wait_clk(1);
        paced_mode = 1'b1;
        wd_limit = 16'h00C8;
        u_host.cs(1'b0);
        u_host.xfer({1'b0, 10'h055, 5'h2}, 16, e0);
        u_host.cs(1'b1);
        u_host.cs(1'b0);
        u_host.xfer(16'h5A3C, 16, e1);
        u_host.cs(1'b1);
        `CHK("gap ok", 3'h0, fault_flags)
        wait_clk(140);
        `CHK("no early", 3'h0, fault_flags)
        wait_clk(160);
        `CHK("timeout", 3'h2, fault_flags)
        `CHK("timeout err", 1'b1, err_state)
        paced_mode = 1'b0;
        wait_clk(2);
        recover(16'h0002);
        // Reset in mid-run drops a held fault and its interrupt
        frame({1'b0, 10'h055, 5'h0}, 1, 12);
        `CHK("pre rst", 3'h1, fault_flags)
        wait_clk(1);
        rst = 1'b1;
        wait_clk(5);
        rst = 1'b0;
        wait_clk(2);
        `CHK("flags rst2", 3'h0, fault_flags)
        `CHK("err rst2", 1'b0, err_state)
        `CHK("irq rst2", 1'b0, fault_irq)
        finish_test();
    end
endmodule : tb_top
